// >>> verilog/cfd_decoder.v
// Control-field decoder: ninth and tenth instruction positions and step timing.
// Assumes the instruction store presents one instruction with a valid strobe and
// that transfer characters arrive one per cycle while the step runs.
//
// Contract
// - Any of 47 ninth-position symbols hands the step to its plugboard hub.
// - Code 1 compares source and destination over 1 to 100 columns.
// - Code 2 compares one to ten ten-position fields, source against destination.
// - Code 3 runs column compare and field compare on one transfer.
// - Code 4 inhibits access-unit alternation for that step.
// - Code 5 clears the accumulator before add, subtract or multiply.
// - Code 6 flags a transfer of all blanks or all zeros.
// - Same-track seek completes in a nominal 50 ms.
// - Disk-to-drum step takes nominally 55 ms, within 30 to 80 ms.
// - Drum-to-disk step takes nominally 105 ms, within 80 to 130 ms.
`timescale 1ns/1ps
`include "cfd_regs.vh"
module cfd_decoder #(
   parameter SEEK_CYC      = `CFD_SEEK_MS * `CFD_CLK_MHZ * 1000,
   parameter DRUM_CYC      = `CFD_DRUM_MS * `CFD_CLK_MHZ * 1000,
   parameter DISK_DRUM_CYC = `CFD_DISK_DRUM_MS * `CFD_CLK_MHZ * 1000,
   parameter DRUM_DISK_CYC = `CFD_DRUM_DISK_MS * `CFD_CLK_MHZ * 1000,
   parameter HUBS          = 47
)(
   input  wire            mclk,
   input  wire            reset,
   input  wire            clk_en,
   input  wire            instr_valid,
   input  wire [5:0]      ctl_char,
   input  wire [3:0]      aux_code,
   input  wire [1:0]      step_kind,
   input  wire [6:0]      col_count,
   input  wire [3:0]      field_count,
   input  wire            xfer_valid,
   input  wire [5:0]      src_char,
   input  wire [5:0]      dst_char,
   output reg             instr_ready,
   output reg  [HUBS-1:0] hub_q,
   output reg             col_cmp_en_q,
   output reg             field_cmp_en_q,
   output reg             seq_inhibit_q,
   output reg             acc_reset_q,
   output reg             col_equal_q,
   output reg             field_equal_q,
   output reg             blank_xmit_q,
   output reg             step_done_q
);
   localparam S_IDLE = 3'b001;
   localparam S_RUN  = 3'b010;
   localparam S_DONE = 3'b100;

   reg [2:0]  state_q;
   reg [31:0] timer_q;
   reg [6:0]  cols_q;
   reg [6:0]  seen_q;
   reg        field_ok_q;
   reg        all_blank_q;
   reg        all_zero_q;
   reg        chk_blank_q;
   reg [31:0] dur_d;
   reg [6:0]  span_d;
   reg        col_equal_d;
   reg        field_equal_d;
   reg        blank_xmit_d;
   wire       ctl_hit;
   wire       take_instr;
   wire       take_char;
   wire       pair_same;
   wire       src_blank;
   wire       src_zero;
   wire       timer_zero;
   wire [31:0] timer_load;
   wire [HUBS-1:0] hub_d;

   // Symbols 1..47 map to hubs 0..46; code 0 means no panel control
   assign ctl_hit    = (ctl_char != 6'h00) && (ctl_char <= HUBS);
   assign take_instr = instr_valid && instr_ready;
   // Characters past the span are ignored so a long transfer cannot spoil the result
   assign take_char  = xfer_valid && (seen_q < cols_q);
   assign pair_same  = (src_char == dst_char);
   assign src_blank  = (src_char == `CFD_CHAR_BLANK);
   assign src_zero   = (src_char == `CFD_CHAR_ZERO);
   // The zero count takes a run cycle, so the timer starts one short; the done state adds one more
   assign timer_zero = (timer_q == 32'h0);
   assign timer_load = (dur_d == 32'h0) ? 32'h0 : dur_d - 32'h1;

   always @*
   begin
      case (step_kind)
         `CFD_KIND_SEEK:      dur_d = SEEK_CYC;
         `CFD_KIND_DISK_DRUM: dur_d = DISK_DRUM_CYC;
         `CFD_KIND_DRUM_DISK: dur_d = DRUM_DISK_CYC;
         default:             dur_d = DRUM_CYC;
      endcase
      // Field compare spans whole ten-position fields, clipped to 1..10 fields
      if (aux_code == `CFD_AUX_FIELD || aux_code == `CFD_AUX_COMBINED)
      begin
         // Ten fields of ten positions meet the same hundred-column ceiling
         if (field_count == 4'h0 || field_count > `CFD_FIELD_MAX)
            span_d = 7'h64;
         else
            span_d = field_count * 7'd10;
      end
      else if (col_count == 7'h00 || col_count > `CFD_COL_MAX)
         span_d = `CFD_COL_MAX;
      else
         span_d = col_count;
   end

   // One comparator per hub; symbol k+1 lights hub k, all others stay dark
   genvar gi;
   generate
      for (gi = 0; gi < HUBS; gi = gi + 1)
      begin : g_hub
         assign hub_d[gi] = ctl_hit && (ctl_char == gi + 1);
      end
   endgenerate

   // Column and field compares share one running flag; a combined step spans
   // whole fields, so both results agree on it
   always @*
   begin
      col_equal_d   = col_cmp_en_q && field_ok_q;
      field_equal_d = field_cmp_en_q && field_ok_q;
      // Either uniform fill counts as a blank transmission
      blank_xmit_d  = chk_blank_q && (all_blank_q || all_zero_q);
   end

   always @(posedge mclk)
   begin
      if (reset)
      begin
         state_q        <= S_IDLE;
         timer_q        <= 32'h0;
         cols_q         <= 7'h00;
         seen_q         <= 7'h00;
         field_ok_q     <= 1'b1;
         all_blank_q    <= 1'b1;
         all_zero_q     <= 1'b1;
         chk_blank_q    <= 1'b0;
         instr_ready    <= 1'b0;
         hub_q          <= {HUBS{1'b0}};
         col_cmp_en_q   <= 1'b0;
         field_cmp_en_q <= 1'b0;
         seq_inhibit_q  <= 1'b0;
         acc_reset_q    <= 1'b0;
         col_equal_q    <= 1'b0;
         field_equal_q  <= 1'b0;
         blank_xmit_q   <= 1'b0;
         step_done_q    <= 1'b0;
      end
      else if (clk_en)
      begin
         step_done_q <= 1'b0;
         acc_reset_q <= 1'b0;
         case (state_q)
            S_IDLE:
            begin
               instr_ready <= 1'b1;
               if (take_instr)
               begin
                  // Ready falls at the taking edge so a held request is never taken twice
                  instr_ready    <= 1'b0;
                  state_q        <= S_RUN;
                  timer_q        <= timer_load;
                  cols_q         <= span_d;
                  seen_q         <= 7'h00;
                  field_ok_q     <= 1'b1;
                  all_blank_q    <= 1'b1;
                  all_zero_q     <= 1'b1;
                  // Hub stands for the whole step so the panel sees a steady level
                  hub_q          <= hub_d;
                  // Codes outside 1..6 leave every auxiliary action off
                  col_cmp_en_q   <= (aux_code == `CFD_AUX_COMPARE) ||
                                    (aux_code == `CFD_AUX_COMBINED);
                  field_cmp_en_q <= (aux_code == `CFD_AUX_FIELD) ||
                                    (aux_code == `CFD_AUX_COMBINED);
                  seq_inhibit_q  <= (aux_code == `CFD_AUX_NOSEQ);
                  // Pulse ahead of the arithmetic so the clear lands first
                  acc_reset_q    <= (aux_code == `CFD_AUX_PRERESET);
                  chk_blank_q    <= (aux_code == `CFD_AUX_BLANKCHK);
                  col_equal_q    <= 1'b0;
                  field_equal_q  <= 1'b0;
                  blank_xmit_q   <= 1'b0;
               end
            end
            S_RUN:
            begin
               if (take_char)
               begin
                  seen_q <= seen_q + 7'h01;
                  if (!pair_same)
                     field_ok_q <= 1'b0;
                  if (!src_blank)
                     all_blank_q <= 1'b0;
                  if (!src_zero)
                     all_zero_q <= 1'b0;
               end
               // Step length is fixed by the transfer kind, not by data arrival
               if (timer_zero)
                  state_q <= S_DONE;
               else
                  timer_q <= timer_q - 32'h1;
            end
            default:
            begin
               // Results and the done pulse leave together so no stale flag is seen
               col_equal_q   <= col_equal_d;
               field_equal_q <= field_equal_d;
               blank_xmit_q  <= blank_xmit_d;
               hub_q         <= {HUBS{1'b0}};
               seq_inhibit_q <= 1'b0;
               step_done_q   <= 1'b1;
               state_q       <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> verilog/cfd_regs.vh
// Constants of the control-field decoder: codes, step kinds and durations.
// Assumes a 100 MHz mclk; included by the decoder module only.
`ifndef CFD_REGS_VH
`define CFD_REGS_VH
`define CFD_CLK_MHZ        100
// Tenth-position auxiliary codes
`define CFD_AUX_COMPARE    4'h1
`define CFD_AUX_FIELD      4'h2
`define CFD_AUX_COMBINED   4'h3
`define CFD_AUX_NOSEQ      4'h4
`define CFD_AUX_PRERESET   4'h5
`define CFD_AUX_BLANKCHK   4'h6
// Step kinds presented with an instruction
`define CFD_KIND_DRUM      2'h0
`define CFD_KIND_SEEK      2'h1
`define CFD_KIND_DISK_DRUM 2'h2
`define CFD_KIND_DRUM_DISK 2'h3
// Nominal step times in milliseconds
`define CFD_SEEK_MS        50
`define CFD_DRUM_MS        30
`define CFD_DISK_DRUM_MS   55
`define CFD_DRUM_DISK_MS   105
// Compare span limits
`define CFD_COL_MAX        7'h64
`define CFD_FIELD_MAX      4'ha
`define CFD_FIELD_WIDTH    10
// Character codes of blank and zero in six-bit form
`define CFD_CHAR_BLANK     6'h00
`define CFD_CHAR_ZERO      6'h0a
`endif

// >>> verification/cfd_chk.sv
// Checker: decode and step-timing relations at the decoder ports.
// Assumes step cycles of 20/10/30/40 (seek/drum/disk-drum/drum-disk) and clk_en high.
`timescale 1ns/1ps
module cfd_chk #(parameter HUBS = 47)(
   input wire logic            mclk,
   input wire logic            reset,
   input wire logic            clk_en,
   input wire logic            instr_valid,
   input wire logic            instr_ready,
   input wire logic [5:0]      ctl_char,
   input wire logic [3:0]      aux_code,
   input wire logic [1:0]      step_kind,
   input wire logic [HUBS-1:0] hub_q,
   input wire logic            col_cmp_en_q,
   input wire logic            field_cmp_en_q,
   input wire logic            seq_inhibit_q,
   input wire logic            acc_reset_q,
   input wire logic            step_done_q
);
   wire tk = clk_en & instr_valid & instr_ready;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   chk_ready_drops: assert property (tk |=> !instr_ready ##1 !instr_ready)
      else $error("ready not dropped");
   chk_drum_time: assert property (tk && step_kind == 2'h0 |=> !step_done_q [*8] ##4 step_done_q)
      else $error("drum step time");
   chk_seek_time: assert property (tk && step_kind == 2'h1 |=> !step_done_q [*8] ##14 step_done_q)
      else $error("seek step time");
   chk_disk_drum: assert property (tk && step_kind == 2'h2 |=> !step_done_q [*8] ##24 step_done_q)
      else $error("disk to drum time");
   chk_drum_disk: assert property (tk && step_kind == 2'h3 |=> !step_done_q [*8] ##34 step_done_q)
      else $error("drum to disk time");
   chk_done_ready: assert property (step_done_q |=> instr_ready && !step_done_q)
      else $error("ready after done");
   chk_hub_select: assert property (tk |=> hub_q == (($past(ctl_char) != 6'h0 &&
      $past(ctl_char) <= 6'h2f) ? {{(HUBS-1){1'b0}}, 1'b1} << ($past(ctl_char) - 6'h1) : '0))
      else $error("hub select");
   chk_aux_enables: assert property (tk |=> {col_cmp_en_q, field_cmp_en_q, seq_inhibit_q} ==
      {$past(aux_code) == 4'h1 || $past(aux_code) == 4'h3,
       $past(aux_code) == 4'h2 || $past(aux_code) == 4'h3, $past(aux_code) == 4'h4})
      else $error("aux enables");
   chk_acc_pulse: assert property (tk && aux_code == 4'h5 |=> acc_reset_q ##1 !acc_reset_q)
      else $error("accumulator reset pulse");
endmodule
bind cfd_decoder cfd_chk #(.HUBS(HUBS)) u_chk (.mclk, .reset, .clk_en, .instr_valid,
   .instr_ready, .ctl_char, .aux_code, .step_kind, .hub_q, .col_cmp_en_q, .field_cmp_en_q,
   .seq_inhibit_q, .acc_reset_q, .step_done_q);

// >>> verification/cfd_store.sv
// Character source model: paired source/destination characters while a step runs.
// Assumes instr_ready stays low for the whole step; position 1 comes first.
`timescale 1ns/1ps
module cfd_store (
   input  wire logic       mclk,
   input  wire logic       instr_ready,
   input  wire logic [1:0] mode,
   input  wire logic [6:0] bad_pos,
   output logic            xfer_valid,
   output logic [5:0]      src_char,
   output logic [5:0]      dst_char
);
   logic [6:0] idx = 7'h0;
   logic       tgl = 1'b0;
   logic [5:0] fill;
   always @(posedge mclk) idx <= instr_ready ? 7'h0 : idx + 7'h1;
   always @(posedge mclk) tgl <= ~tgl;
   // Off-step lines toggle each cycle so a stray sample never looks like data
   always @*
   begin
      fill = mode == 2'h2 ? 6'h00 : mode == 2'h3 ? 6'h0a : idx[5:0] ^ 6'h15;
      xfer_valid = !instr_ready;
      src_char = instr_ready ? {6{tgl}} : fill;
      dst_char = (idx + 7'h1 == bad_pos) ? ~src_char : src_char;
   end
endmodule

// >>> verification/tb.sv
// Testbench: decode, compare, blank check and step timing of the decoder.
// Assumes the character source model and the bound checker.
`timescale 1ns/1ps
module tb;
   logic        mclk = 0, reset = 1, instr_valid = 0;
   logic [5:0]  ctl_char = 0;
   logic [3:0]  aux_code = 0, field_count = 4'h1;
   logic [1:0]  step_kind = 0, mode = 0;
   logic [6:0]  col_count = 7'h8, bad_pos = 0;
   logic [5:0]  src_char, dst_char;
   logic [46:0] hub_q;
   logic        xfer_valid, instr_ready, col_cmp_en_q, field_cmp_en_q, seq_inhibit_q;
   logic        acc_reset_q, col_equal_q, field_equal_q, blank_xmit_q, step_done_q;
   logic [50:0] snap;
   int          cyc, n_errors = 0, checks_done = 0;
   cfd_decoder #(.SEEK_CYC(20), .DRUM_CYC(10), .DISK_DRUM_CYC(30), .DRUM_DISK_CYC(40)) DUT (
      .mclk, .reset, .clk_en(1'b1), .instr_valid, .ctl_char, .aux_code, .step_kind, .col_count,
      .field_count, .xfer_valid, .src_char, .dst_char, .instr_ready, .hub_q, .col_cmp_en_q,
      .field_cmp_en_q, .seq_inhibit_q, .acc_reset_q, .col_equal_q, .field_equal_q,
      .blank_xmit_q, .step_done_q);
   cfd_store u_store (.mclk, .instr_ready, .mode, .bad_pos, .xfer_valid, .src_char, .dst_char);
   initial forever #5 mclk = ~mclk;
   task automatic conclude;
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One whole step: offer, hold until taken, snapshot the step levels, wait for done
   task automatic step(input logic [20:0] v);
      {ctl_char, aux_code, step_kind, mode, bad_pos} = v;
      instr_valid = 1'b1;
      for (cyc = 0; instr_ready !== 1'b1 && cyc < 99; cyc++) @(posedge mclk) #1;
      if (cyc >= 99)
      begin
         n_errors++;
         conclude;
      end
      @(posedge mclk) #1;
      instr_valid = 1'b0;
      snap = {hub_q, col_cmp_en_q, field_cmp_en_q, seq_inhibit_q, acc_reset_q};
      for (cyc = 1; step_done_q !== 1'b1 && cyc < 99; cyc++) @(posedge mclk) #1;
      if (cyc >= 99)
      begin
         n_errors++;
         conclude;
      end
   endtask
   task automatic t_hub;
      for (int i = 0; i < 49; i++)
      begin
         step({i[5:0], 15'h0});
         cmp(snap[50:4], (i > 0 && i < 48) ? 47'h1 << (i - 1) : 47'h0);
      end
      $display("hub test done");
   endtask
   task automatic t_aux;
      for (int i = 0; i < 16; i++)
      begin
         step({6'h0, i[3:0], 11'h0});
         cmp(snap[3:0], {i == 1 || i == 3, i == 2 || i == 3, i == 4, i == 5});
      end
      $display("aux test done");
   endtask
   task automatic t_time;
      for (int k = 0; k < 4; k++)
      begin
         step({10'h0, k[1:0], 9'h0});
         cmp(cyc, k == 0 ? 12 : k == 1 ? 22 : k == 2 ? 32 : 42);
      end
      $display("time test done");
   endtask
   task automatic t_cmp;
      step({10'h1, 2'h3, 9'h9});
      cmp(col_equal_q, 1'b1);
      step({10'h1, 2'h3, 9'h8});
      cmp(col_equal_q, 1'b0);
      step({10'h2, 2'h3, 9'hb});
      cmp(field_equal_q, 1'b1);
      step({10'h2, 2'h3, 9'ha});
      cmp(field_equal_q, 1'b0);
      step({10'h3, 2'h3, 9'ha});
      cmp({col_equal_q, field_equal_q}, 2'h0);
      step({10'h3, 2'h3, 9'hb});
      cmp({col_equal_q, field_equal_q}, 2'h3);
      $display("compare test done");
   endtask
   task automatic t_blank;
      for (int m = 0; m < 4; m++)
      begin
         step({10'h6, 2'h3, m[1:0], 7'h0});
         cmp(blank_xmit_q, m > 1);
      end
      $display("blank test done");
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      #1 reset = 0;
      t_hub;
      t_aux;
      t_time;
      t_cmp;
      t_blank;
      conclude;
   end
endmodule
